//--- cls_cfg_master.sv
`include "cls_regs.vh"
module cls_cfg_master (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] phase_i,
  input  wire logic       go_i,
  input  wire logic [3:0] dly_i,
  output logic            start_o,
  output logic            done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  // start from Idle, reload from Run
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      start_o <= 1'h0;
      done_o <= 1'h0;
    end else begin
      start_o <= go_i && (phase_i == `CLS_PH_IDLE || phase_i == `CLS_PH_RUN);
      cnt <= (phase_i == `CLS_PH_DOWNLOAD) ? cnt + 4'h1 : 4'h0;
      done_o <= phase_i == `CLS_PH_DOWNLOAD && cnt == dly_i;
    end
  end
endmodule

//--- cls_checker.sv
`include "cls_regs.vh"
module cls_checker (
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       supply_good_i,
  input wire logic       manual_reset_i,
  input wire logic       cfg_start_pin_i,
  input wire logic       cfg_chip_select_i,
  input wire logic       download_done_i,
  input wire logic [2:0] phase_o,
  input wire logic [2:0] sampled_mode_o,
  input wire logic       cfg_if_drive_o,
  input wire logic       clear_status_pin_cfg_o,
  input wire logic       cfg_serial_data_in_cfg_o,
  input wire logic       cfg_chip_select_cfg_o,
  input wire logic       gpio_pullup_default_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  por_hold_a: assert property (phase_o == `CLS_PH_POWER_ON && !supply_good_i
    |=> phase_o == `CLS_PH_POWER_ON) else $error("power-on left without supply");
  por_exit_a: assert property (phase_o == `CLS_PH_POWER_ON && supply_good_i
    |=> phase_o == `CLS_PH_CLEAR) else $error("no clear after supply good");
  sample_pins_a: assert property (phase_o == `CLS_PH_SAMPLE |-> cfg_if_drive_o
    && clear_status_pin_cfg_o && gpio_pullup_default_o && !cfg_chip_select_cfg_o)
    else $error("pin roles wrong in sampling");
  mode0_dl_a: assert property ($past(phase_o) == `CLS_PH_SAMPLE
    && phase_o == `CLS_PH_DOWNLOAD |-> sampled_mode_o == `CLS_MODE_MASTER)
    else $error("download entered without mode 0");
  other_idle_a: assert property ($past(phase_o) == `CLS_PH_SAMPLE
    && phase_o == `CLS_PH_IDLE |-> sampled_mode_o != `CLS_MODE_MASTER)
    else $error("idle entered with mode 0");
  idle_rel_a: assert property (phase_o == `CLS_PH_IDLE |-> !cfg_if_drive_o
    && !clear_status_pin_cfg_o && !cfg_serial_data_in_cfg_o) else $error("idle still drives");
  idle_stay_a: assert property (phase_o == `CLS_PH_IDLE && !cfg_start_pin_i
    && !manual_reset_i |=> phase_o == `CLS_PH_IDLE) else $error("idle left without start");
  mreset_a: assert property (manual_reset_i && phase_o != `CLS_PH_POWER_ON
    |=> phase_o == `CLS_PH_MAN_RESET) else $error("manual reset not taken");
  mrel_a: assert property (phase_o == `CLS_PH_MAN_RESET && !manual_reset_i
    |=> phase_o == `CLS_PH_CLEAR) else $error("no clear after manual reset");
  run_a: assert property (phase_o == `CLS_PH_DOWNLOAD && download_done_i
    && !manual_reset_i |=> phase_o == `CLS_PH_RUN) else $error("run not entered");
  cs_gate_a: assert property (phase_o == `CLS_PH_IDLE && !cfg_chip_select_i
    && cfg_start_pin_i && sampled_mode_o == `CLS_MODE_SLAVE_CS && !manual_reset_i
    |=> phase_o == `CLS_PH_IDLE) else $error("mode 1 start without chip select");
  idle_c: cover property (phase_o == `CLS_PH_IDLE && cfg_start_pin_i);
  run_c: cover property (phase_o == `CLS_PH_RUN);
  mres_c: cover property (phase_o == `CLS_PH_MAN_RESET);
endmodule
bind cls_lifecycle cls_checker chk_u (.clk_sys_i, .rst_i, .supply_good_i, .manual_reset_i,
  .cfg_start_pin_i, .cfg_chip_select_i, .download_done_i, .phase_o, .sampled_mode_o,
  .cfg_if_drive_o, .clear_status_pin_cfg_o, .cfg_serial_data_in_cfg_o, .cfg_chip_select_cfg_o,
  .gpio_pullup_default_o);

//--- cls_lifecycle.v
// Operation
// - After power-up the sequencer waits for supply good, then clears the whole memory.
// - In power-on the clear cycle is repeated for a fixed built-in time.
// - Manual reset holds the reset phase and one clear cycle runs on release.
// - Both reset phases lead to mode sampling, which drives config pins and samples mode.
// - Sampled modes 0, 1 and 7 are master serial, slave with chip select and slave serial.
// - Mode 0 goes straight to download, any other mode to Idle.
// - Idle releases the configuration interface and does nothing.
// - From Idle download starts only on the start pin, then the sequencer runs it.
// - Each multiplexed pin function follows the current phase.
// - Reset and sampling phases dedicate the configuration pins to configuration.
// - Unconfigured in reset and sampling, general-purpose pins stay pulled-up inputs.
// - In sampling the chip select pin is general purpose.
// - Idle returns clear-status, data, low and high pins to pulled-up inputs.
// - Download runs in one of five contexts chosen by the sampled mode and by entry from Idle or Run.
`include "cls_regs.vh"
module cls_lifecycle #(
  parameter POR_CLEAR_CYCLES = `CLS_POR_CLEAR_CYCLES,
  parameter CLEAR_CYCLES     = `CLS_CLEAR_CYCLES
) (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire       supply_good_i,
  input  wire       manual_reset_i,
  input  wire [2:0] cfg_mode_select_pins_i,
  input  wire       cfg_start_pin_i,
  input  wire       cfg_chip_select_i,
  input  wire       download_done_i,
  output reg  [2:0] phase_o,
  output reg  [2:0] sampled_mode_o,
  output reg  [2:0] download_ctx_o,
  output reg        mode_valid_o,
  output reg        clear_active_o,
  output reg        download_active_o,
  output reg        cfg_if_drive_o,
  output reg        clear_status_pin_cfg_o,
  output reg        cfg_serial_data_in_cfg_o,
  output reg        low_during_cfg_pin_cfg_o,
  output reg        high_during_cfg_pin_cfg_o,
  output reg        cfg_chip_select_cfg_o,
  output reg        gpio_pullup_default_o
);
  ////////////////////////////////////////////////////////////////
  reg  [2:0]  phase;
  reg  [2:0]  next_phase;
  reg  [15:0] cnt;
  reg         configured;
  reg         from_idle;
  reg         next_configured;
  wire        cnt_done = (cnt == 16'h0000);

  function [2:0] ctx_of;
    input [2:0] mode;
    input       trig;
    input       reload;
    begin
      if (reload)
        ctx_of = `CLS_CTX_RELOAD;
      else if (mode == `CLS_MODE_SLAVE_CS)
        ctx_of = `CLS_CTX_SLAVE_CS;
      else if (mode == `CLS_MODE_SLAVE)
        ctx_of = `CLS_CTX_SLAVE;
      else if (trig)
        ctx_of = `CLS_CTX_MASTER_TRIG;
      else
        ctx_of = `CLS_CTX_MASTER;
    end
  endfunction

  // Mode in force: pins while sampling, held value after
  function [2:0] mode_now;
    input [2:0] cur_phase;
    input [2:0] pins;
    input [2:0] held;
    begin
      if (cur_phase == `CLS_PH_SAMPLE)
        mode_now = pins;
      else
        mode_now = held;
    end
  endfunction

  // Dual-use pin keeps its configuration role
  function cfg_role;
    input [2:0] ph;
    begin
      cfg_role = (ph != `CLS_PH_IDLE) && (ph != `CLS_PH_RUN);
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  always @* begin
    next_phase = phase;
    case (phase)
      `CLS_PH_POWER_ON: begin
        if (supply_good_i)
          next_phase = `CLS_PH_CLEAR;
      end
      `CLS_PH_MAN_RESET: begin
        if (!manual_reset_i)
          next_phase = `CLS_PH_CLEAR;
      end
      `CLS_PH_CLEAR: begin
        if (cnt_done)
          next_phase = `CLS_PH_SAMPLE;
      end
      `CLS_PH_SAMPLE: begin
        if (cnt_done)
          next_phase = (cfg_mode_select_pins_i == `CLS_MODE_MASTER) ?
                       `CLS_PH_DOWNLOAD : `CLS_PH_IDLE;
      end
      // start pin, chip select gates mode 1
      `CLS_PH_IDLE: begin
        if (cfg_start_pin_i &&
            (sampled_mode_o != `CLS_MODE_SLAVE_CS || cfg_chip_select_i))
          next_phase = `CLS_PH_DOWNLOAD;
      end
      `CLS_PH_DOWNLOAD: begin
        if (download_done_i)
          next_phase = `CLS_PH_RUN;
      end
      // Reload from Run
      `CLS_PH_RUN: begin
        if (cfg_start_pin_i)
          next_phase = `CLS_PH_DOWNLOAD;
      end
      default: next_phase = `CLS_PH_POWER_ON;
    endcase
    if (manual_reset_i && phase != `CLS_PH_POWER_ON)
      next_phase = `CLS_PH_MAN_RESET;
  end

  always @* begin
    next_configured = configured;
    if (next_phase == `CLS_PH_CLEAR || next_phase == `CLS_PH_MAN_RESET)
      next_configured = 1'b0;
    if (phase == `CLS_PH_DOWNLOAD && next_phase == `CLS_PH_RUN)
      next_configured = 1'b1;
  end

  ////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      phase      <= `CLS_PH_POWER_ON;
      cnt        <= 16'h0000;
      configured <= 1'b0;
      from_idle  <= 1'b0;
      sampled_mode_o <= 3'h0;
      mode_valid_o   <= 1'b0;
      download_ctx_o <= 3'h0;
    end else begin
      phase <= next_phase;
      if (next_phase != phase) begin
        case (next_phase)
          `CLS_PH_CLEAR: cnt <= (phase == `CLS_PH_POWER_ON) ?
                               POR_CLEAR_CYCLES[15:0] : CLEAR_CYCLES[15:0];
          `CLS_PH_SAMPLE: cnt <= `CLS_SAMPLE_CYCLES;
          default: cnt <= 16'h0000;
        endcase
      end else if (!cnt_done) begin
        cnt <= cnt - 16'h0001;
      end
      configured <= next_configured;
      if (phase == `CLS_PH_SAMPLE && cnt_done) begin
        sampled_mode_o <= cfg_mode_select_pins_i;
        mode_valid_o   <= (cfg_mode_select_pins_i == `CLS_MODE_MASTER) ||
                          (cfg_mode_select_pins_i == `CLS_MODE_SLAVE_CS) ||
                          (cfg_mode_select_pins_i == `CLS_MODE_SLAVE);
      end
      if (next_phase == `CLS_PH_DOWNLOAD && phase != `CLS_PH_DOWNLOAD) begin
        from_idle <= (phase == `CLS_PH_IDLE);
        download_ctx_o <= ctx_of(mode_now(phase, cfg_mode_select_pins_i, sampled_mode_o),
                                 phase == `CLS_PH_IDLE, phase == `CLS_PH_RUN);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pin function per phase
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      phase_o                   <= `CLS_PH_POWER_ON;
      clear_active_o            <= 1'b0;
      download_active_o         <= 1'b0;
      cfg_if_drive_o            <= 1'b0;
      clear_status_pin_cfg_o    <= 1'b1;
      cfg_serial_data_in_cfg_o  <= 1'b1;
      low_during_cfg_pin_cfg_o  <= 1'b1;
      high_during_cfg_pin_cfg_o <= 1'b1;
      cfg_chip_select_cfg_o     <= 1'b0;
      gpio_pullup_default_o     <= 1'b1;
    end else begin
      phase_o           <= next_phase;
      clear_active_o    <= (next_phase == `CLS_PH_CLEAR);
      download_active_o <= (next_phase == `CLS_PH_DOWNLOAD);
      // drive in sampling, released in idle
      cfg_if_drive_o    <= (next_phase == `CLS_PH_SAMPLE) ||
                           (next_phase == `CLS_PH_DOWNLOAD);
      clear_status_pin_cfg_o    <= cfg_role(next_phase);
      cfg_serial_data_in_cfg_o  <= cfg_role(next_phase);
      low_during_cfg_pin_cfg_o  <= cfg_role(next_phase);
      high_during_cfg_pin_cfg_o <= cfg_role(next_phase);
      // chip select config only in mode 1 download
      cfg_chip_select_cfg_o <= (next_phase == `CLS_PH_DOWNLOAD) &&
        (mode_now(phase, cfg_mode_select_pins_i, sampled_mode_o) == `CLS_MODE_SLAVE_CS);
      gpio_pullup_default_o <= !next_configured ||
                               (next_phase == `CLS_PH_MAN_RESET) ||
                               (next_phase == `CLS_PH_CLEAR) ||
                               (next_phase == `CLS_PH_DOWNLOAD && from_idle &&
                                phase == `CLS_PH_DOWNLOAD);
    end
  end
endmodule

//--- cls_regs.vh
`ifndef CLS_REGS_VH
`define CLS_REGS_VH
// Phase codes
`define CLS_PH_POWER_ON   3'h0
`define CLS_PH_MAN_RESET  3'h1
`define CLS_PH_CLEAR      3'h2
`define CLS_PH_SAMPLE     3'h3
`define CLS_PH_IDLE       3'h4
`define CLS_PH_DOWNLOAD   3'h5
`define CLS_PH_RUN        3'h6
// Mode-select encodings, highest pin first
`define CLS_MODE_MASTER   3'h0
`define CLS_MODE_SLAVE_CS 3'h1
`define CLS_MODE_SLAVE    3'h7
// Download contexts
`define CLS_CTX_MASTER      3'h0
`define CLS_CTX_SLAVE_CS    3'h1
`define CLS_CTX_SLAVE       3'h2
`define CLS_CTX_MASTER_TRIG 3'h3
`define CLS_CTX_RELOAD      3'h4
// Timing defaults in clock cycles
`define CLS_POR_CLEAR_CYCLES 16'h0400
`define CLS_CLEAR_CYCLES     16'h0040
`define CLS_SAMPLE_CYCLES    16'h0002
`endif

//--- testbench.sv
`include "cls_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 0, rst_i = 1, supply_good_i = 0, manual_reset_i = 0, go = 0, csel = 1;
  logic [2:0] mode = 3'h0;
  logic [3:0] dly = 4'h0;
  // Slave scenarios: mode pins, context, phase while chip select is low
  logic [2:0] mt [2] = '{`CLS_MODE_SLAVE, `CLS_MODE_SLAVE_CS};
  logic [2:0] ct [2] = '{`CLS_CTX_SLAVE, `CLS_CTX_SLAVE_CS};
  logic [2:0] pt [2] = '{`CLS_PH_DOWNLOAD, `CLS_PH_IDLE};
  wire  [2:0] phase, smode, ctx;
  wire        start, done, mvalid, clr, dla, drv, f_cs, f_sd, f_ld, f_hd, f_chip, pull;
  int         n_errors = 0, num_checks = 0, cyc = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  cls_lifecycle #(.POR_CLEAR_CYCLES(8), .CLEAR_CYCLES(4)) dut_u (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .supply_good_i(supply_good_i), .manual_reset_i(manual_reset_i),
    .cfg_mode_select_pins_i(mode), .cfg_start_pin_i(start), .cfg_chip_select_i(csel),
    .download_done_i(done), .phase_o(phase), .sampled_mode_o(smode), .download_ctx_o(ctx),
    .mode_valid_o(mvalid), .clear_active_o(clr), .download_active_o(dla),
    .cfg_if_drive_o(drv), .clear_status_pin_cfg_o(f_cs), .cfg_serial_data_in_cfg_o(f_sd),
    .low_during_cfg_pin_cfg_o(f_ld), .high_during_cfg_pin_cfg_o(f_hd),
    .cfg_chip_select_cfg_o(f_chip), .gpio_pullup_default_o(pull));
  cls_cfg_master pm_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .phase_i(phase), .go_i(go),
    .dly_i(dly),
    .start_o(start), .done_o(done));
  task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_phase(input logic [2:0] ph);
    @(negedge clk_sys_i);
    for (int n = 0; n < 200 && phase !== ph; n++) @(negedge clk_sys_i);
    chk(phase, ph);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys_i) if (++cyc == 2000) begin
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    repeat (5) @(negedge clk_sys_i);
    chk(phase, `CLS_PH_POWER_ON);
    @(posedge clk_sys_i);
    supply_good_i <= 1'h1;
    wait_phase(`CLS_PH_CLEAR);
    chk({clr, f_cs, pull}, 3'h7);
    repeat (8) @(negedge clk_sys_i);
    chk(phase, `CLS_PH_CLEAR);
    @(negedge clk_sys_i);
    chk(phase, `CLS_PH_SAMPLE);
    chk({drv, pull, f_chip}, 3'h6);
    wait_phase(`CLS_PH_DOWNLOAD);
    chk(ctx, `CLS_CTX_MASTER);
    chk(smode, `CLS_MODE_MASTER);
    wait_phase(`CLS_PH_RUN);
    $display("Test power-on master done");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys_i);
      manual_reset_i <= 1'h1;
      mode <= mt[i];
      dly <= 4'h5;
      repeat (2) @(negedge clk_sys_i);
      chk(phase, `CLS_PH_MAN_RESET);
      @(posedge clk_sys_i);
      manual_reset_i <= 1'h0;
      wait_phase(`CLS_PH_CLEAR);
      wait_phase(`CLS_PH_IDLE);
      chk(smode, mt[i]);
      chk({drv, f_cs, f_sd}, 3'h0);
      chk({f_ld, f_hd, pull}, 3'h1);
      chk({mvalid, dla, clr}, 3'h4);
      repeat (5) @(negedge clk_sys_i);
      chk(phase, `CLS_PH_IDLE);
      @(posedge clk_sys_i);
      go <= 1'h1;
      csel <= 1'h0;
      repeat (4) @(negedge clk_sys_i);
      chk(phase, pt[i]);
      @(posedge clk_sys_i);
      csel <= 1'h1;
      wait_phase(`CLS_PH_DOWNLOAD);
      chk(ctx, ct[i]);
      chk({2'h0, f_chip}, i[2:0]);
      @(posedge clk_sys_i);
      go <= 1'h0;
      wait_phase(`CLS_PH_RUN);
      chk({f_cs, f_sd, pull}, 3'h0);
      $display("Test slave mode %0d done", mt[i]);
    end
    @(posedge clk_sys_i);
    go <= 1'h1;
    wait_phase(`CLS_PH_DOWNLOAD);
    chk(ctx, `CLS_CTX_RELOAD);
    chk({pull, f_cs, drv}, 3'h3);
    @(posedge clk_sys_i);
    go <= 1'h0;
    wait_phase(`CLS_PH_RUN);
    $display("Test reload done");
    give_verdict();
  end
endmodule
